// ===== shared/cscm_pkg.sv
// Functional notes
// - Bypass input bypasses canceller, clears coefficients
// - Nonlinear-off input disables nonlinear processor per channel
// - Freeze input holds coefficients, stops adaptation
// - Law-off input skips law conversion
// - Clear-mode input acts as bypass plus law-off
// - Flex input applies the software-selected function
// - Inputs active high; low means no effect
// - Bypass monitor: 1 canceller off, 0 on
// - Nonlinear monitor: 1 disabled, 0 active
// - Hold monitor: 1 coefficients frozen
// - Clear monitor: 1 coefficients being reset
// - Flex report A uses select bits 7:4
// - Flex report B uses select bits 3:0
// - Streams carry 32 channels, one bit each
// - Report choices: idle, tones, double talk, silence
// - Law monitor: 1 conversion disabled
// - Clear-mode monitor equals bypass and law-off
package cscm_pkg;

	// ----------------------------------------------------------------
	// Frame geometry
	// ----------------------------------------------------------------
	localparam int          CHAN_COUNT = 32;
	localparam int          CHAN_W     = 5;
	localparam logic [4:0]  CHAN_FIRST = 5'h00;
	localparam logic [4:0]  CHAN_LAST  = 5'h1F;
	localparam logic [4:0]  CHAN_STEP  = 5'h01;

	// ----------------------------------------------------------------
	// Register map (byte offsets)
	// ----------------------------------------------------------------
	localparam int          ADDR_W           = 8;
	localparam logic [7:0]  REG_INPUT_MASK   = 8'h00;
	localparam logic [7:0]  REG_FLEX_CTRL    = 8'h04;
	localparam logic [7:0]  REG_FLEX_REPORT  = 8'h08;
	localparam logic [7:0]  REG_IRQ_STATUS   = 8'h0C;
	localparam logic [7:0]  REG_IRQ_MASK     = 8'h10;
	localparam logic [7:0]  REG_BYPASS_STATE = 8'h14;
	localparam logic [7:0]  REG_CLEAR_STATE  = 8'h18;
	localparam logic [7:0]  REG_FRAME_STATUS = 8'h1C;

	// Input mask bit positions, reset value
	localparam int          MASK_BYPASS   = 0;
	localparam int          MASK_NONLIN   = 1;
	localparam int          MASK_HOLD     = 2;
	localparam int          MASK_LAW      = 3;
	localparam int          MASK_CLEAR    = 4;
	localparam int          MASK_FLEX     = 5;
	localparam int          MASK_W        = 6;
	localparam logic [5:0]  MASK_RESET    = 6'h00;

	// Interrupt bit positions
	localparam int          IRQ_FRAME     = 0;
	localparam int          IRQ_BYPASS    = 1;
	localparam int          IRQ_FLEX_A    = 2;
	localparam int          IRQ_FLEX_B    = 3;
	localparam int          IRQ_SYNC_LOST = 4;
	localparam int          IRQ_W         = 5;
	localparam logic [4:0]  IRQ_RESET     = 5'h00;

	// Frame status field positions
	localparam int          FST_LOCKED    = 8;

	// ----------------------------------------------------------------
	// Flex function and report codes
	// ----------------------------------------------------------------
	localparam logic [3:0]  FLEX_CTRL_RESET   = 4'h0;
	localparam logic [7:0]  FLEX_REPORT_RESET = 8'h00;
	localparam int          SEL_A_HI = 7;
	localparam int          SEL_A_LO = 4;
	localparam int          SEL_B_HI = 3;
	localparam int          SEL_B_LO = 0;

	localparam logic [3:0]  FCTL_NONE       = 4'h0;
	localparam logic [3:0]  FCTL_BYPASS     = 4'h1;
	localparam logic [3:0]  FCTL_NONLIN_OFF = 4'h2;
	localparam logic [3:0]  FCTL_HOLD       = 4'h3;
	localparam logic [3:0]  FCTL_LAW_OFF    = 4'h4;
	localparam logic [3:0]  FCTL_COEF_CLEAR = 4'h5;
	localparam logic [3:0]  FCTL_CLEAR_MODE = 4'h6;

	localparam logic [3:0]  FREP_NONE        = 4'h0;
	localparam logic [3:0]  FREP_IDLE        = 4'h1;
	localparam logic [3:0]  FREP_TONE_2010   = 4'h2;
	localparam logic [3:0]  FREP_TONE_2100   = 4'h3;
	localparam logic [3:0]  FREP_TONE_2100PR = 4'h4;
	localparam logic [3:0]  FREP_DOUBLE_TALK = 4'h5;
	localparam logic [3:0]  FREP_NO_SPEECH   = 4'h6;
	localparam logic [3:0]  FREP_ANY_2100    = 4'h7;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef logic [CHAN_COUNT-1:0] cscm_vec_type;

	typedef struct packed {
		logic chan_bypass_in;
		logic chan_nonlinear_off_in;
		logic chan_coef_hold_in;
		logic chan_law_conv_off_in;
		logic chan_clear_mode_in;
		logic chan_flex_ctrl_in;
	} cscm_serial_in_type;

	typedef struct packed {
		logic bypass_state_out;
		logic nonlinear_off_state_out;
		logic coef_hold_state_out;
		logic coef_clear_state_out;
		logic flex_report_a_out;
		logic flex_report_b_out;
		logic law_conv_off_state_out;
		logic clear_mode_state_out;
	} cscm_serial_out_type;

	// Per-channel requests made by the speech control of the core
	typedef struct packed {
		cscm_vec_type bypass;
		cscm_vec_type nonlin_off;
		cscm_vec_type hold;
		cscm_vec_type coef_clear;
	} cscm_core_req_type;

	// Per-channel detector results from the core
	typedef struct packed {
		cscm_vec_type idle;
		cscm_vec_type tone_2010;
		cscm_vec_type tone_2100;
		cscm_vec_type tone_2100_pr;
		cscm_vec_type double_talk;
		cscm_vec_type no_speech;
	} cscm_detect_type;

	// Per-channel commands to the canceller core
	typedef struct packed {
		cscm_vec_type bypass;
		cscm_vec_type nonlin_off;
		cscm_vec_type hold;
		cscm_vec_type law_off;
		cscm_vec_type coef_clear;
		cscm_vec_type speech_reset;
	} cscm_chan_ctl_type;

	typedef enum logic [0:0] {
		CSCM_HUNT,
		CSCM_RUN
	} cscm_frame_type;

endpackage : cscm_pkg

// ===== rtl/cscm_serial_ctrl.sv
`timescale 1ns/100ps
module cscm_serial_ctrl
	import cscm_pkg::*;
(
	// Clock, reset, enable
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire logic                clk_en,
	// Highway timing (same clock domain)
	input  wire logic                bit_strobe,
	input  wire logic                frame_sync,
	// Serial control pins
	input  wire cscm_serial_in_type  serial_in,
	// Serial monitor pins
	output cscm_serial_out_type      serial_out,
	// Core side
	input  wire cscm_core_req_type   core_req,
	input  wire cscm_detect_type     detect,
	output cscm_chan_ctl_type        chan_ctl,
	// Register port
	input  wire logic [ADDR_W-1:0]   reg_addr,
	input  wire logic [31:0]         reg_wdata,
	input  wire logic                reg_write,
	input  wire logic                reg_read,
	output logic      [31:0]         reg_rdata,
	// Interrupt
	output logic                     irq
);

	// ----------------------------------------------------------------
	// Reset release and pin synchronisers
	// ----------------------------------------------------------------
	logic               rst_meta_n;
	logic               rst_sync_n;
	cscm_serial_in_type pin_meta;
	cscm_serial_in_type pin_sync;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_n <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_sync_n <= rst_meta_n;
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else if (clk_en) begin
			pin_meta <= serial_in;
			pin_sync <= pin_meta;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [MASK_W-1:0] input_mask;
	logic [3:0]        flex_ctrl_select;
	logic [7:0]        flex_report_select;
	logic [IRQ_W-1:0]  irq_status;
	logic [IRQ_W-1:0]  irq_mask;

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			input_mask         <= MASK_RESET;
			flex_ctrl_select   <= FLEX_CTRL_RESET;
			flex_report_select <= FLEX_REPORT_RESET;
			irq_mask           <= IRQ_RESET;
		end else if (clk_en && reg_write) begin
			case (reg_addr)
				REG_INPUT_MASK:  input_mask         <= reg_wdata[MASK_W-1:0];
				REG_FLEX_CTRL:   flex_ctrl_select   <= reg_wdata[3:0];
				REG_FLEX_REPORT: flex_report_select <= reg_wdata[7:0];
				REG_IRQ_MASK:    irq_mask           <= reg_wdata[IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Frame tracking
	// ----------------------------------------------------------------
	cscm_frame_type      frame_state;
	cscm_frame_type      next_frame_state;
	logic [CHAN_W-1:0]   chan;
	logic [CHAN_W-1:0]   next_chan;
	logic                slot_take;
	logic                sync_lost;

	// Channel n is bit n after the sync pulse
	always_comb begin
		next_frame_state = frame_state;
		next_chan        = chan;
		slot_take        = 1'b0;
		sync_lost        = 1'b0;
		case (frame_state)
			CSCM_HUNT: begin
				if (bit_strobe && frame_sync) begin
					next_frame_state = CSCM_RUN;
					next_chan        = CHAN_FIRST;
					slot_take        = 1'b1;
				end
			end
			CSCM_RUN: begin
				if (bit_strobe) begin
					if (frame_sync) begin
						next_chan = CHAN_FIRST;
						slot_take = 1'b1;
					end else if (chan == CHAN_LAST) begin
						// Frame overran 32 slots: stop driving, wait for sync
						next_frame_state = CSCM_HUNT;
						sync_lost        = 1'b1;
					end else begin
						next_chan = chan + CHAN_STEP;
						slot_take = 1'b1;
					end
				end
			end
			default: begin
				next_frame_state = CSCM_HUNT;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			frame_state <= CSCM_HUNT;
			chan        <= CHAN_FIRST;
		end else if (clk_en) begin
			frame_state <= next_frame_state;
			chan        <= next_chan;
		end
	end

	// ----------------------------------------------------------------
	// Per-channel capture of serial controls
	// ----------------------------------------------------------------
	cscm_vec_type ext_bypass;
	cscm_vec_type ext_nonlin;
	cscm_vec_type ext_hold;
	cscm_vec_type ext_law;
	cscm_vec_type ext_clear;
	cscm_vec_type ext_flex;

	// A masked input reads as low, and low has no effect
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ext_bypass <= '0;
			ext_nonlin <= '0;
			ext_hold   <= '0;
			ext_law    <= '0;
			ext_clear  <= '0;
			ext_flex   <= '0;
		end else if (clk_en && slot_take) begin
			ext_bypass[next_chan] <= pin_sync.chan_bypass_in
				& ~input_mask[MASK_BYPASS];
			ext_nonlin[next_chan] <= pin_sync.chan_nonlinear_off_in
				& ~input_mask[MASK_NONLIN];
			ext_hold[next_chan]   <= pin_sync.chan_coef_hold_in
				& ~input_mask[MASK_HOLD];
			ext_law[next_chan]    <= pin_sync.chan_law_conv_off_in
				& ~input_mask[MASK_LAW];
			ext_clear[next_chan]  <= pin_sync.chan_clear_mode_in
				& ~input_mask[MASK_CLEAR];
			ext_flex[next_chan]   <= pin_sync.chan_flex_ctrl_in
				& ~input_mask[MASK_FLEX];
		end
	end

	// ----------------------------------------------------------------
	// Effective per-channel state
	// ----------------------------------------------------------------
	function automatic cscm_vec_type flex_pick(input logic [3:0] sel, input logic [3:0] code,
		input cscm_vec_type flex);
		flex_pick = (sel == code) ? flex : '0;
	endfunction : flex_pick

	cscm_vec_type req_bypass;
	cscm_vec_type req_law;
	cscm_vec_type eff_bypass;
	cscm_vec_type eff_nonlin;
	cscm_vec_type eff_hold;
	cscm_vec_type eff_law;
	cscm_vec_type eff_clear;

	always_comb begin
		// Clear mode behaves as bypass plus law-off
		req_bypass = ext_bypass | ext_clear
			| flex_pick(flex_ctrl_select, FCTL_BYPASS, ext_flex)
			| flex_pick(flex_ctrl_select, FCTL_CLEAR_MODE, ext_flex);
		req_law    = ext_law | ext_clear
			| flex_pick(flex_ctrl_select, FCTL_LAW_OFF, ext_flex)
			| flex_pick(flex_ctrl_select, FCTL_CLEAR_MODE, ext_flex);
		eff_bypass = req_bypass | core_req.bypass;
		// A bypassed channel also skips the nonlinear processor
		eff_nonlin = ext_nonlin | core_req.nonlin_off | eff_bypass
			| flex_pick(flex_ctrl_select, FCTL_NONLIN_OFF, ext_flex);
		eff_hold   = ext_hold | core_req.hold
			| flex_pick(flex_ctrl_select, FCTL_HOLD, ext_flex);
		eff_law    = req_law;
		eff_clear  = req_bypass | core_req.coef_clear
			| flex_pick(flex_ctrl_select, FCTL_COEF_CLEAR, ext_flex);
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			chan_ctl <= '0;
		end else if (clk_en) begin
			chan_ctl.bypass       <= eff_bypass;
			chan_ctl.nonlin_off   <= eff_nonlin;
			chan_ctl.hold         <= eff_hold;
			chan_ctl.law_off      <= eff_law;
			chan_ctl.coef_clear   <= eff_clear;
			chan_ctl.speech_reset <= req_bypass;
		end
	end

	// ----------------------------------------------------------------
	// Detector selection for flex reports
	// ----------------------------------------------------------------
	function automatic cscm_vec_type report_pick(input logic [3:0] sel,
		input cscm_detect_type det);
		case (sel)
			FREP_IDLE:        report_pick = det.idle;
			FREP_TONE_2010:   report_pick = det.tone_2010;
			FREP_TONE_2100:   report_pick = det.tone_2100;
			FREP_TONE_2100PR: report_pick = det.tone_2100_pr;
			FREP_DOUBLE_TALK: report_pick = det.double_talk;
			FREP_NO_SPEECH:   report_pick = det.no_speech;
			FREP_ANY_2100:    report_pick = det.tone_2100 | det.tone_2100_pr;
			default:          report_pick = '0;
		endcase
	endfunction : report_pick

	cscm_vec_type rep_a;
	cscm_vec_type rep_b;

	always_comb begin
		rep_a = report_pick(flex_report_select[SEL_A_HI:SEL_A_LO], detect);
		rep_b = report_pick(flex_report_select[SEL_B_HI:SEL_B_LO], detect);
	end

	// ----------------------------------------------------------------
	// Monitor streams
	// ----------------------------------------------------------------
	// Each bit stands for one whole slot; low while hunting for sync
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			serial_out <= '0;
		end else if (clk_en) begin
			if (slot_take) begin
				serial_out.bypass_state_out        <= eff_bypass[next_chan];
				serial_out.nonlinear_off_state_out <= eff_nonlin[next_chan];
				serial_out.coef_hold_state_out     <= eff_hold[next_chan];
				serial_out.coef_clear_state_out    <= eff_clear[next_chan];
				serial_out.flex_report_a_out       <= rep_a[next_chan];
				serial_out.flex_report_b_out       <= rep_b[next_chan];
				serial_out.law_conv_off_state_out  <= eff_law[next_chan];
				serial_out.clear_mode_state_out    <= eff_bypass[next_chan]
					& eff_law[next_chan];
			end else if (sync_lost) begin
				serial_out <= '0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	cscm_vec_type     bypass_seen;
	logic [IRQ_W-1:0] irq_set;
	logic [IRQ_W-1:0] irq_clr;

	always_comb begin
		irq_set                = '0;
		irq_set[IRQ_FRAME]     = slot_take && next_chan == CHAN_LAST;
		irq_set[IRQ_BYPASS]    = bypass_seen != eff_bypass;
		irq_set[IRQ_FLEX_A]    = slot_take && rep_a[next_chan];
		irq_set[IRQ_FLEX_B]    = slot_take && rep_b[next_chan];
		irq_set[IRQ_SYNC_LOST] = sync_lost;
		irq_clr                = (reg_write && reg_addr == REG_IRQ_STATUS)
			? reg_wdata[IRQ_W-1:0] : '0;
	end

	// A set in the same cycle as its clear is kept
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			irq_status  <= IRQ_RESET;
			bypass_seen <= '0;
		end else if (clk_en) begin
			irq_status  <= (irq_status & ~irq_clr) | irq_set;
			bypass_seen <= eff_bypass;
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			irq <= 1'b0;
		end else if (clk_en) begin
			irq <= |(((irq_status & ~irq_clr) | irq_set) & irq_mask);
		end
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	logic [31:0] next_rdata;

	always_comb begin
		next_rdata = '0;
		case (reg_addr)
			REG_INPUT_MASK:   next_rdata[MASK_W-1:0] = input_mask;
			REG_FLEX_CTRL:    next_rdata[3:0]        = flex_ctrl_select;
			REG_FLEX_REPORT:  next_rdata[7:0]        = flex_report_select;
			REG_IRQ_STATUS:   next_rdata[IRQ_W-1:0]  = irq_status;
			REG_IRQ_MASK:     next_rdata[IRQ_W-1:0]  = irq_mask;
			REG_BYPASS_STATE: next_rdata             = eff_bypass;
			REG_CLEAR_STATE:  next_rdata             = eff_bypass & eff_law;
			REG_FRAME_STATUS: begin
				next_rdata[CHAN_W-1:0] = chan;
				next_rdata[FST_LOCKED] = frame_state == CSCM_RUN;
			end
			default:          next_rdata = '0;
		endcase
	end

	// Data stand only in the cycle after the read strobe
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			reg_rdata <= '0;
		end else if (clk_en) begin
			reg_rdata <= reg_read ? next_rdata : '0;
		end
	end

endmodule : cscm_serial_ctrl

// ===== verification/cscm_serial_ctrl_sva.sv
`timescale 1ns/100ps
module cscm_serial_ctrl_sva
	import cscm_pkg::*;
(
	// Clock and reset
	input wire logic                clk,
	input wire logic                rst_n,
	// Watched ports
	input wire logic                clk_en,
	input wire logic                bit_strobe,
	input wire cscm_serial_out_type serial_out,
	input wire logic [ADDR_W-1:0]   reg_addr,
	input wire logic [31:0]         reg_wdata,
	input wire logic                reg_write,
	input wire logic                reg_read,
	input wire logic [31:0]         reg_rdata,
	input wire logic                irq
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	sequence s_mask_wr;
		clk_en && reg_write && reg_addr == REG_INPUT_MASK;
	endsequence
	sequence s_mask_rd;
		clk_en && reg_read && reg_addr == REG_INPUT_MASK;
	endsequence
	property p_clear_mon;
		serial_out.clear_mode_state_out ==
			(serial_out.bypass_state_out && serial_out.law_conv_off_state_out);
	endproperty
	property p_bypass_nonlin;
		serial_out.bypass_state_out |-> serial_out.nonlinear_off_state_out;
	endproperty
	property p_bypass_coef;
		serial_out.bypass_state_out |-> serial_out.coef_clear_state_out;
	endproperty
	// Monitors move only on a slot edge
	property p_slot_hold;
		!bit_strobe |=> $stable(serial_out);
	endproperty
	property p_mask_back;
		s_mask_wr ##1 s_mask_rd |=> reg_rdata == 32'($past(reg_wdata[5:0], 2));
	endproperty
	property p_rdata_idle;
		!(clk_en && reg_read) |=> reg_rdata == '0;
	endproperty
	property p_irq_mask;
		clk_en && reg_write && reg_addr == REG_IRQ_MASK && reg_wdata[IRQ_W-1:0] == 5'h00
			|-> ##2 !irq;
	endproperty
	property p_reset_quiet;
		$rose(rst_n) |-> serial_out == '0 && !irq && reg_rdata == '0;
	endproperty

	a_clear_mon: assert property (p_clear_mon)
		else $error("clear mode monitor is not bypass and law-off");
	a_bypass_nonlin: assert property (p_bypass_nonlin)
		else $error("bypass without nonlinear off");
	a_bypass_coef: assert property (p_bypass_coef)
		else $error("bypass without coefficient reset");
	a_slot_hold: assert property (p_slot_hold)
		else $error("monitor changed between slot edges");
	a_mask_back: assert property (p_mask_back)
		else $error("mask read back differs");
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data not zero when idle");
	a_irq_mask: assert property (p_irq_mask)
		else $error("irq high with all masked");
	a_reset_quiet: assert property (p_reset_quiet)
		else $error("outputs not quiet at reset release");
endmodule : cscm_serial_ctrl_sva

bind cscm_serial_ctrl cscm_serial_ctrl_sva cscm_serial_ctrl_sva_inst (
	.clk        (clk),
	.rst_n      (rst_n),
	.clk_en     (clk_en),
	.bit_strobe (bit_strobe),
	.serial_out (serial_out),
	.reg_addr   (reg_addr),
	.reg_wdata  (reg_wdata),
	.reg_write  (reg_write),
	.reg_read   (reg_read),
	.reg_rdata  (reg_rdata),
	.irq        (irq)
);

// ===== verification/cscm_far_end.sv
`timescale 1ns/100ps
module cscm_far_end
	import cscm_pkg::*;
#(
	// Nearest whole divide of 10 MHz down to 256 kbit/s
	parameter int DIV = 39
)
(
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                rst_n,
	// Channel patterns and captured monitors
	input  wire logic [5:0][31:0]    ctl_vec,
	output logic      [7:0][31:0]    frame_mon,
	output logic      [15:0]         frame_count,
	// Serial link
	output logic                     bit_strobe,
	output logic                     frame_sync,
	output cscm_serial_in_type       serial_in,
	input  wire cscm_serial_out_type serial_out
);
	logic [5:0]       div;
	logic [4:0]       slot;
	logic             strobe_d;
	logic             done;
	logic [7:0][31:0] mon;

	// Pins hold for the whole slot so the sync flops settle first
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			serial_in[i] = ctl_vec[i][slot];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div        <= 6'h00;
			slot       <= 5'h00;
			bit_strobe <= 1'b0;
			frame_sync <= 1'b0;
		end else begin
			div        <= (div == 6'(DIV - 1)) ? 6'h00 : div + 6'h01;
			bit_strobe <= (div == 6'(DIV - 2));
			frame_sync <= (div == 6'(DIV - 2)) && (slot == 5'h00);
			if (bit_strobe) begin
				slot <= slot + 5'h01;
			end
		end
	end

	// Monitor bit of a slot is read one cycle after its strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			strobe_d    <= 1'b0;
			done        <= 1'b0;
			mon         <= '0;
			frame_mon   <= '0;
			frame_count <= 16'h0000;
		end else begin
			strobe_d <= bit_strobe;
			done     <= strobe_d && (slot == 5'h00);
			if (strobe_d) begin
				for (int f = 0; f < 8; f++) begin
					mon[f][slot - 5'h01] <= serial_out[f];
				end
			end
			if (done) begin
				frame_mon   <= mon;
				frame_count <= frame_count + 16'h0001;
			end
		end
	end
endmodule : cscm_far_end

// ===== verification/tb_top.sv
`timescale 1ns/100ps
module tb_top
	import cscm_pkg::*;
;
	logic                clk = 1'b0;
	logic                rst_n;
	logic                clk_en;
	logic                bit_strobe;
	logic                frame_sync;
	cscm_serial_in_type  serial_in;
	cscm_serial_out_type serial_out;
	cscm_core_req_type   core_req;
	cscm_detect_type     det;
	logic [7:0]          reg_addr;
	logic [31:0]         reg_wdata;
	logic                reg_write;
	logic                reg_read;
	logic [31:0]         reg_rdata;
	logic                irq;
	logic [5:0][31:0]    ctl_vec;
	logic [7:0][31:0]    frame_mon;
	logic [15:0]         frame_count;
	logic [31:0]         rd;
	int                  failures = 0;
	int                  cmp_count = 0;

	always #50 clk = ~clk;

	cscm_serial_ctrl cscm_serial_ctrl_inst (
		.clk        (clk),
		.rst_n      (rst_n),
		.clk_en     (clk_en),
		.bit_strobe (bit_strobe),
		.frame_sync (frame_sync),
		.serial_in  (serial_in),
		.serial_out (serial_out),
		.core_req   (core_req),
		.detect     (det),
		.chan_ctl   (),
		.reg_addr   (reg_addr),
		.reg_wdata  (reg_wdata),
		.reg_write  (reg_write),
		.reg_read   (reg_read),
		.reg_rdata  (reg_rdata),
		.irq        (irq)
	);
	cscm_far_end cscm_far_end_inst (
		.clk         (clk),
		.rst_n       (rst_n),
		.ctl_vec     (ctl_vec),
		.frame_mon   (frame_mon),
		.frame_count (frame_count),
		.bit_strobe  (bit_strobe),
		.frame_sync  (frame_sync),
		.serial_in   (serial_in),
		.serial_out  (serial_out)
	);

	// ----------------------------------------------------------------
	// Shared tasks, entered right after a rising edge; check_irq calls check right after a falling edge
	// ----------------------------------------------------------------
	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : stop_test

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Any access, read or write, may follow at once
	task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask : write_reg

	task automatic read_reg(input logic [7:0] a, output logic [31:0] d);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		@(negedge clk);
		d = reg_rdata;
		@(posedge clk);
	endtask : read_reg

	task automatic wr_chk(input logic [7:0] a, input logic [31:0] d);
		write_reg(a, d);
		read_reg(a, rd);
		check(rd, d);
	endtask : wr_chk

	task automatic wait_frames(input int n);
		int target;
		target = frame_count + n;
		repeat ((n + 1) * 1400) if (frame_count != 16'(target)) @(posedge clk);
		if (frame_count != 16'(target)) failures++;
	endtask : wait_frames

	task automatic check_irq(input logic e);
		@(posedge clk);
		@(negedge clk);
		check(32'(irq), 32'(e));
		@(posedge clk);
	endtask : check_irq

	function automatic logic [31:0] rep(input logic [3:0] c);
		case (c)
			FREP_IDLE:        return det.idle;
			FREP_TONE_2010:   return det.tone_2010;
			FREP_TONE_2100:   return det.tone_2100;
			FREP_TONE_2100PR: return det.tone_2100_pr;
			FREP_DOUBLE_TALK: return det.double_talk;
			FREP_NO_SPEECH:   return det.no_speech;
			FREP_ANY_2100:    return det.tone_2100 | det.tone_2100_pr;
			default:          return 32'h0000_0000;
		endcase
	endfunction : rep

	function automatic logic [7:0][31:0] exp_mon(input logic [5:0] m, input logic [3:0] fc,
		input logic [7:0] fr);
		logic [5:0][31:0] v;
		logic [7:0][31:0] e;
		for (int i = 0; i < 6; i++) begin
			v[i] = ctl_vec[i] & ~{32{m[5 - i]}};
		end
		e[7] = v[5] | v[1] | ((fc == FCTL_BYPASS || fc == FCTL_CLEAR_MODE) ? v[0] : '0);
		e[6] = v[4] | e[7] | ((fc == FCTL_NONLIN_OFF) ? v[0] : '0);
		e[5] = v[3] | ((fc == FCTL_HOLD) ? v[0] : '0);
		e[4] = e[7] | ((fc == FCTL_COEF_CLEAR) ? v[0] : '0);
		e[3] = rep(fr[7:4]);
		e[2] = rep(fr[3:0]);
		e[1] = v[2] | v[1] | ((fc == FCTL_LAW_OFF || fc == FCTL_CLEAR_MODE) ? v[0] : '0);
		e[0] = e[7] & e[1];
		return e;
	endfunction : exp_mon

	task automatic check_frame(input logic [7:0][31:0] e);
		wait_frames(3);
		check(frame_mon[7], e[7]);
		check(frame_mon[6], e[6]);
		check(frame_mon[5], e[5]);
		check(frame_mon[4], e[4]);
		check(frame_mon[3], e[3]);
		check(frame_mon[2], e[2]);
		check(frame_mon[1], e[1]);
		check(frame_mon[0], e[0]);
	endtask : check_frame

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset_regs();
		logic [7:0] a [6];
		a = '{REG_INPUT_MASK, REG_FLEX_CTRL, REG_FLEX_REPORT, REG_IRQ_STATUS,
			REG_IRQ_MASK, 8'h20};
		for (int i = 0; i < 6; i++) begin
			read_reg(a[i], rd);
			check(rd, '0);
		end
	endtask : t_reset_regs

	// Edge channels 0 and 31 included; flex pin set but unselected
	task automatic t_direct();
		ctl_vec <= {32'h8000_0011, 32'h0000_0100, 32'h0000_1000, 32'h0001_0000,
			32'h0010_0000, 32'h0100_0000};
		@(posedge clk);
		check_frame(exp_mon(6'h00, FCTL_NONE, 8'h00));
	endtask : t_direct

	task automatic t_mask();
		logic [5:0] m;
		for (int i = 0; i < 2; i++) begin
			m = (i == 0) ? 6'h3F : 6'h15;
			wr_chk(REG_INPUT_MASK, {26'h000_0000, m});
			check_frame(exp_mon(m, FCTL_NONE, 8'h00));
		end
		wr_chk(REG_INPUT_MASK, 32'h0000_0000);
	endtask : t_mask

	task automatic t_flex_ctrl();
		for (int c = 1; c < 7; c++) begin
			wr_chk(REG_FLEX_CTRL, 32'(c));
			check_frame(exp_mon(6'h00, 4'(c), 8'h00));
		end
	endtask : t_flex_ctrl

	task automatic t_flex_report();
		logic [7:0] s;
		det <= {32'h0000_0003, 32'h0000_0030, 32'h0000_0300, 32'h0000_3000,
			32'h0003_0000, 32'h0030_0000};
		for (int c = 0; c < 9; c++) begin
			s = {4'(c), 4'(8 - c)};
			wr_chk(REG_FLEX_REPORT, {24'h00_0000, s});
			check_frame(exp_mon(6'h00, FCTL_CLEAR_MODE, s));
		end
	endtask : t_flex_report

	task automatic t_irq();
		wr_chk(REG_IRQ_MASK, 32'h0000_0001);
		wait_frames(1);
		check_irq(1'b1);
		read_reg(REG_IRQ_STATUS, rd);
		check(rd & 32'h0000_0001, 32'h0000_0001);
		write_reg(REG_IRQ_STATUS, 32'h0000_0001);
		check_irq(1'b0);
		wait_frames(1);
		check_irq(1'b1);
		wr_chk(REG_IRQ_MASK, 32'h0000_0000);
		check_irq(1'b0);
	endtask : t_irq

	initial begin
		rst_n     = 1'b0;
		clk_en    = 1'b1;
		core_req  = '0;
		det       = '0;
		ctl_vec   = '0;
		reg_addr  = 8'h00;
		reg_wdata = 32'h0000_0000;
		reg_write = 1'b0;
		reg_read  = 1'b0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset_regs();
		t_direct();
		t_mask();
		t_flex_ctrl();
		t_flex_report();
		t_irq();
		stop_test();
	end

	initial begin
		repeat (100000) @(posedge clk);
		failures++;
		stop_test();
	end
endmodule : tb_top
